// ---- bench/tmr2_regs_tb.sv ----
// Self-checking bench for the timer2 registers and the compare modulator
`include "tmr2_defines.svh"
`default_nettype none
module tmr2_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, rst_n, timer_tick, global_irq_enable, legacy_fuse;
	logic compare_vector_ack, overflow_vector_ack;
	logic shared_pin_output_latch, shared_pin_direction;
	logic modulating_compare_output;
	logic [1:0] wave_mode, carrier_mode, modulating_mode;
	tmr2_pkg::tmr2_io_req_type io_req;
	logic [7:0] io_rdata, v, g, m_cnt, m_ocr, m_flags, m_mask;
	logic carrier_compare_output, compare_irq_req, overflow_irq_req;
	logic shared_pin_out, shared_pin_oe_n, exp_oc, m_blk, e;
	int n_fail, total_checks, i;

	tmr2_regs uut (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.io_req(io_req),
		.io_rdata(io_rdata),
		.timer_tick(timer_tick),
		.wave_mode(wave_mode),
		.carrier_mode(carrier_mode),
		.modulating_mode(modulating_mode),
		.modulating_compare_output(modulating_compare_output),
		.global_irq_enable(global_irq_enable),
		.compare_vector_ack(compare_vector_ack),
		.overflow_vector_ack(overflow_vector_ack),
		.shared_pin_output_latch(shared_pin_output_latch),
		.shared_pin_direction(shared_pin_direction),
		.legacy_fuse(legacy_fuse),
		.carrier_compare_output(carrier_compare_output),
		.compare_irq_req(compare_irq_req),
		.overflow_irq_req(overflow_irq_req),
		.shared_pin_out(shared_pin_out),
		.shared_pin_oe_n(shared_pin_oe_n)
	);

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic chk8(input string nm, input logic [7:0] x,
		input logic [7:0] y);
		total_checks++;
		if (y !== x) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, x, y);
		end
	endtask

	task automatic chk1(input string nm, input logic x, input logic y);
		total_checks++;
		if (y !== x) begin
			n_fail++;
			$display("BAD %s exp %b got %b", nm, x, y);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// Model follows every write; flags clear only where a one is written
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		io_req.we = 1'b1;
		io_req.addr = a;
		io_req.wdata = d;
		@(negedge ref_clk);
		io_req.we = 1'b0;
		io_req.wdata = ~d;
		case (a)
			`TMR2_ADDR_COMPARE: m_ocr = d;
			`TMR2_ADDR_COUNT: begin
				m_cnt = d;
				m_blk = 1'b1;
			end
			`TMR2_ADDR_FLAGS: m_flags = m_flags & ~(d & 8'hc0);
			`TMR2_ADDR_MASK: m_mask = d & 8'hc0;
			default: ;
		endcase
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		io_req.re = 1'b1;
		io_req.addr = a;
		@(negedge ref_clk);
		io_req.re = 1'b0;
		d = io_rdata;
	endtask

	task automatic pulse(input int n);
		repeat (n) begin
			@(negedge ref_clk);
			timer_tick = 1'b1;
			@(negedge ref_clk);
			timer_tick = 1'b0;
		end
	endtask

	// Normal mode model step: match blocked right after a count write
	task automatic tick(input int n);
		repeat (n) begin
			pulse(1);
			if (!m_blk && m_cnt == m_ocr) begin
				m_flags[7] = 1'b1;
				if (carrier_mode == 2'h1)
					exp_oc = ~exp_oc;
			end
			if (m_cnt == 8'hff)
				m_flags[6] = 1'b1;
			m_cnt = m_cnt + 8'h01;
			m_blk = 1'b0;
		end
	endtask

	task automatic wrap_up();
		if (n_fail == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#100us;
		n_fail++;
		wrap_up();
	end

	initial begin
		{rst_n, timer_tick, global_irq_enable, legacy_fuse} = 4'h0;
		{compare_vector_ack, overflow_vector_ack} = 2'h0;
		{shared_pin_output_latch, shared_pin_direction} = 2'h0;
		modulating_compare_output = 1'b0;
		{wave_mode, carrier_mode, modulating_mode} = 6'h00;
		io_req = '0;
		{m_cnt, m_ocr, m_flags, m_mask} = 32'h0000_0000;
		{exp_oc, m_blk} = 2'h0;
		void'($urandom(16908));
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		rd(`TMR2_ADDR_COMPARE, g); chk8("ocr_rst", 8'h00, g);
		rd(`TMR2_ADDR_COUNT, g); chk8("cnt_rst", 8'h00, g);
		rd(`TMR2_ADDR_FLAGS, g); chk8("flg_rst", 8'h00, g);
		rd(`TMR2_ADDR_MASK, g); chk8("msk_rst", 8'h00, g);
		rd(6'h3f, g); chk8("unmapped", 8'h00, g);
		v = 8'($urandom);
		wr(`TMR2_ADDR_COUNT, v);
		rd(`TMR2_ADDR_COUNT, g); chk8("cnt_rw", m_cnt, g);
		wr(`TMR2_ADDR_COMPARE, ~v);
		rd(`TMR2_ADDR_COMPARE, g); chk8("ocr_rw", m_ocr, g);
		wr(`TMR2_ADDR_MASK, 8'hff);
		rd(`TMR2_ADDR_MASK, g); chk8("msk_rw", m_mask, g);
		// Match on the first tick after a counter write is blocked
		wr(`TMR2_ADDR_COMPARE, 8'h10);
		wr(`TMR2_ADDR_COUNT, 8'h10);
		tick(1);
		rd(`TMR2_ADDR_FLAGS, g); chk8("blocked", m_flags, g);
		carrier_mode = 2'h1;
		wr(`TMR2_ADDR_COUNT, 8'h0f);
		tick(2);
		rd(`TMR2_ADDR_FLAGS, g); chk8("cmp_set", m_flags, g);
		rd(`TMR2_ADDR_COUNT, g); chk8("cnt_run", m_cnt, g);
		chk1("carrier", exp_oc, carrier_compare_output);
		chk1("cirq_gl0", 1'b0, compare_irq_req);
		global_irq_enable = 1'b1;
		wait_n(2);
		chk1("cirq_on", 1'b1, compare_irq_req);
		chk1("oirq_off", 1'b0, overflow_irq_req);
		wr(`TMR2_ADDR_FLAGS, 8'h00);
		rd(`TMR2_ADDR_FLAGS, g); chk8("w0_keep", m_flags, g);
		compare_vector_ack = 1'b1;
		wait_n(1);
		compare_vector_ack = 1'b0;
		m_flags[7] = 1'b0;
		rd(`TMR2_ADDR_FLAGS, g); chk8("cmp_ack", m_flags, g);
		chk1("cirq_clr", 1'b0, compare_irq_req);
		wr(`TMR2_ADDR_COUNT, 8'hfe);
		tick(2);
		rd(`TMR2_ADDR_FLAGS, g); chk8("ovf_set", m_flags, g);
		chk1("oirq_on", 1'b1, overflow_irq_req);
		global_irq_enable = 1'b0;
		wait_n(2);
		chk1("oirq_gl0", 1'b0, overflow_irq_req);
		wr(`TMR2_ADDR_FLAGS, 8'h40);
		rd(`TMR2_ADDR_FLAGS, g); chk8("ovf_w1c", m_flags, g);
		wr(`TMR2_ADDR_COUNT, 8'hff);
		tick(1);
		overflow_vector_ack = 1'b1;
		wait_n(1);
		overflow_vector_ack = 1'b0;
		m_flags[6] = 1'b0;
		rd(`TMR2_ADDR_FLAGS, g); chk8("ovf_ack", m_flags, g);
		// Phase correct: up to top, down to bottom, flag on reversal at bottom
		carrier_mode = 2'h0;
		wave_mode = 2'h1;
		wr(`TMR2_ADDR_FLAGS, 8'hc0);
		wr(`TMR2_ADDR_COUNT, 8'hfe);
		pulse(256);
		rd(`TMR2_ADDR_COUNT, g); chk8("pc_bottom", 8'h00, g);
		rd(`TMR2_ADDR_FLAGS, g); chk1("pc_early", 1'b0, g[6]);
		pulse(1);
		rd(`TMR2_ADDR_FLAGS, g); chk1("pc_ovf", 1'b1, g[6]);
		// CTC: clear on match, counter wraps at the compare value
		wave_mode = 2'h2;
		carrier_mode = 2'h2;
		wr(`TMR2_ADDR_FLAGS, 8'hc0);
		wr(`TMR2_ADDR_COUNT, 8'h0e);
		pulse(3);
		rd(`TMR2_ADDR_COUNT, g); chk8("ctc_wrap", 8'h00, g);
		chk1("ctc_oc", 1'b0, carrier_compare_output);
		rd(`TMR2_ADDR_FLAGS, g); chk1("ctc_flag", 1'b1, g[7]);
		// Fast PWM non-inverting: set at bottom, clear on match
		wave_mode = 2'h3;
		wr(`TMR2_ADDR_COUNT, 8'hfe);
		pulse(2);
		chk1("fpwm_bot", 1'b1, carrier_compare_output);
		rd(`TMR2_ADDR_FLAGS, g); chk1("fpwm_ovf", 1'b1, g[6]);
		wr(`TMR2_ADDR_COUNT, 8'h0f);
		pulse(2);
		chk1("fpwm_cmp", 1'b0, carrier_compare_output);
		exp_oc = 1'b0;
		wave_mode = 2'h0;
		wr(`TMR2_ADDR_FLAGS, 8'hc0);
		m_flags = 8'h00;
		// Modulator: random modes, latch, direction and fuse
		for (i = 0; i < 40; i++) begin
			if (i == 20) begin
				carrier_mode = 2'h1;
				wr(`TMR2_ADDR_COUNT, m_ocr - 8'h01);
				tick(2);
				chk1("carrier_tg", exp_oc, carrier_compare_output);
			end
			@(negedge ref_clk);
			{carrier_mode, modulating_mode, shared_pin_output_latch,
				shared_pin_direction, legacy_fuse,
				modulating_compare_output} = 8'($urandom);
			wait_n(4);
			if (carrier_mode != 2'h0 && modulating_mode != 2'h0 &&
				!legacy_fuse)
				e = shared_pin_output_latch ?
					(exp_oc | modulating_compare_output) :
					(exp_oc & modulating_compare_output);
			else if (carrier_mode != 2'h0)
				e = exp_oc;
			else if (modulating_mode != 2'h0 && !legacy_fuse)
				e = modulating_compare_output;
			else
				e = shared_pin_output_latch;
			chk1("pin_out", e, shared_pin_out);
			chk1("pin_oe_n", ~shared_pin_direction, shared_pin_oe_n);
		end
		wrap_up();
	end
endmodule // tmr2_regs_tb
`default_nettype wire

// ---- rtl/tmr2_defines.svh ----
// Offsets, bit positions and reset values of the timer2 register block
// Overview of operation
// - Software reads and writes counter value directly
// - Counter write suppresses compare on next tick
// - Compare value checked against counter every count
// - Compare interrupt needs enable, flag, global enable
// - Overflow interrupt needs enable, flag, global enable
// - Counter equal to compare value sets flag
// - Compare flag cleared by vector or one
// - Counter overflow sets overflow flag
// - Overflow flag cleared by vector or one
// - Phase correct mode flags overflow at bottom
// - Enabled compare outputs replace pin latch value
// - Both outputs enabled combine them automatically
// - Pin latch selects AND or OR combining
// - Pin driver enabled only by direction bit
// - Legacy fuse mode disables the modulator
// - Modulation lowers resolution by carrier period
`ifndef TMR2_DEFINES_SVH
`define TMR2_DEFINES_SVH

`define TMR2_ADDR_COMPARE 6'h23
`define TMR2_ADDR_COUNT 6'h24
`define TMR2_ADDR_FLAGS 6'h36
`define TMR2_ADDR_MASK 6'h37

`define TMR2_CMP_BIT 7
`define TMR2_OVF_BIT 6

`define TMR2_RST_COUNT 8'h00
`define TMR2_RST_COMPARE 8'h00
`define TMR2_RST_FLAGS 8'h00
`define TMR2_RST_MASK 8'h00
`define TMR2_RST_PIN_OE_N 1'b1

`define TMR2_MAX 8'hff
`define TMR2_BOTTOM 8'h00
`define TMR2_MODE_OFF 2'h0

`endif

// ---- rtl/tmr2_modulator.sv ----
// Output compare modulator driving the shared port pin
`include "tmr2_defines.svh"
`default_nettype none
module tmr2_modulator (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic carrier_compare_output,
	input wire logic modulating_compare_output,
	input wire logic [1:0] carrier_mode,
	input wire logic [1:0] modulating_mode,
	input wire logic shared_pin_output_latch,
	input wire logic shared_pin_direction,
	input wire logic legacy_mode,
	output logic pin_out,
	output logic pin_oe_n
);
	tmr2_pkg::tmr2_mod_state_type s_r;
	tmr2_pkg::tmr2_mod_state_type s_nxt;
	logic car_on;
	logic mod_on;

	always_comb begin
		s_nxt = s_r;
		car_on = carrier_mode != `TMR2_MODE_OFF;
		mod_on = modulating_mode != `TMR2_MODE_OFF;
		s_nxt.pin_oe_n = !shared_pin_direction;
		if (car_on && mod_on && !legacy_mode) begin
			// Edges snap to carrier cycles, costing modulating resolution
			if (shared_pin_output_latch) begin
				s_nxt.pin_out = carrier_compare_output |
					modulating_compare_output;
			end else begin
				s_nxt.pin_out = carrier_compare_output &
					modulating_compare_output;
			end
		end else if (car_on) begin
			s_nxt.pin_out = carrier_compare_output;
		end else if (mod_on && !legacy_mode) begin
			s_nxt.pin_out = modulating_compare_output;
		end else begin
			s_nxt.pin_out = shared_pin_output_latch;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_r.pin_out <= 1'b0;
			s_r.pin_oe_n <= `TMR2_RST_PIN_OE_N;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pin_out = s_r.pin_out;
	assign pin_oe_n = s_r.pin_oe_n;

	property p_oe_dir;
		@(posedge ref_clk) disable iff (!rst_n)
		1'b1 |=> pin_oe_n == !$past(shared_pin_direction);
	endproperty
	a_oe_dir: assert property (p_oe_dir)
		else $error("pin enable not following direction");

	property p_mod_and;
		@(posedge ref_clk) disable iff (!rst_n)
		car_on && mod_on && !legacy_mode && !shared_pin_output_latch
		|=> pin_out == ($past(carrier_compare_output) &&
			$past(modulating_compare_output));
	endproperty
	a_mod_and: assert property (p_mod_and)
		else $error("modulator AND result wrong");

	property p_mod_or;
		@(posedge ref_clk) disable iff (!rst_n)
		car_on && mod_on && !legacy_mode && shared_pin_output_latch
		|=> pin_out == ($past(carrier_compare_output) ||
			$past(modulating_compare_output));
	endproperty
	a_mod_or: assert property (p_mod_or)
		else $error("modulator OR result wrong");

	property p_legacy;
		@(posedge ref_clk) disable iff (!rst_n)
		legacy_mode && car_on
		|=> pin_out == $past(carrier_compare_output);
	endproperty
	a_legacy: assert property (p_legacy)
		else $error("modulator active in legacy mode");

	c_mod_or: cover property (@(posedge ref_clk) disable iff (!rst_n)
		car_on && mod_on && !legacy_mode && shared_pin_output_latch);
endmodule // tmr2_modulator
`default_nettype wire

// ---- rtl/tmr2_pkg.sv ----
// Types shared by the timer2 register block and its modulator
`default_nettype none
package tmr2_pkg;

	typedef enum logic [1:0] {
		TMR2_NORMAL,
		TMR2_PHASE_PWM,
		TMR2_CTC,
		TMR2_FAST_PWM
	} tmr2_wave_type;

	typedef struct packed {
		logic we;
		logic re;
		logic [5:0] addr;
		logic [7:0] wdata;
	} tmr2_io_req_type;

	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] ocr;
		logic flag_cmp;
		logic flag_ovf;
		logic mask_cmp;
		logic mask_ovf;
		logic block;
		logic dir_down;
		logic oc2;
		logic cmp_irq;
		logic ovf_irq;
		logic fuse_meta;
		logic fuse_sync;
		logic [7:0] rdata;
	} tmr2_state_type;

	typedef struct packed {
		logic pin_out;
		logic pin_oe_n;
	} tmr2_mod_state_type;

endpackage
`default_nettype wire

// ---- rtl/tmr2_regs.sv ----
// Timer2 counter, compare and interrupt flag registers with pin output
`include "tmr2_defines.svh"
`default_nettype none
module tmr2_regs (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire tmr2_pkg::tmr2_io_req_type io_req,
	output logic [7:0] io_rdata,
	input wire logic timer_tick,
	input wire logic [1:0] wave_mode,
	input wire logic [1:0] carrier_mode,
	input wire logic [1:0] modulating_mode,
	input wire logic modulating_compare_output,
	input wire logic global_irq_enable,
	input wire logic compare_vector_ack,
	input wire logic overflow_vector_ack,
	input wire logic shared_pin_output_latch,
	input wire logic shared_pin_direction,
	input wire logic legacy_fuse,
	output logic carrier_compare_output,
	output logic compare_irq_req,
	output logic overflow_irq_req,
	output logic shared_pin_out,
	output logic shared_pin_oe_n
);
	tmr2_pkg::tmr2_state_type s_r;
	tmr2_pkg::tmr2_state_type s_nxt;
	tmr2_pkg::tmr2_wave_type wave;
	logic cmp_evt;
	logic ovf_evt;
	logic wr_cnt;
	logic wr_ocr;
	logic wr_flg;
	logic wr_msk;

	function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
		hit = a == b;
	endfunction

	always_comb begin
		s_nxt = s_r;
		wave = tmr2_pkg::tmr2_wave_type'(wave_mode);
		cmp_evt = 1'b0;
		ovf_evt = 1'b0;
		wr_cnt = io_req.we && hit(io_req.addr, `TMR2_ADDR_COUNT);
		wr_ocr = io_req.we && hit(io_req.addr, `TMR2_ADDR_COMPARE);
		wr_flg = io_req.we && hit(io_req.addr, `TMR2_ADDR_FLAGS);
		wr_msk = io_req.we && hit(io_req.addr, `TMR2_ADDR_MASK);
		// Fuse is a pin level, so it is synchronised
		s_nxt.fuse_meta = legacy_fuse;
		s_nxt.fuse_sync = s_r.fuse_meta;

		if (timer_tick) begin
			s_nxt.block = 1'b0;
			// A blocked tick still counts, it only loses its match
			cmp_evt = (s_r.cnt == s_r.ocr) && !s_r.block;
			case (wave)
				tmr2_pkg::TMR2_NORMAL,
				tmr2_pkg::TMR2_FAST_PWM: begin
					s_nxt.cnt = s_r.cnt + 8'h01;
					ovf_evt = s_r.cnt == `TMR2_MAX;
				end
				tmr2_pkg::TMR2_CTC: begin
					if (s_r.cnt == s_r.ocr) begin
						s_nxt.cnt = `TMR2_BOTTOM;
					end else begin
						s_nxt.cnt = s_r.cnt + 8'h01;
					end
					ovf_evt = s_r.cnt == `TMR2_MAX;
				end
				tmr2_pkg::TMR2_PHASE_PWM: begin
					if (s_r.dir_down) begin
						if (s_r.cnt == `TMR2_BOTTOM) begin
							s_nxt.dir_down = 1'b0;
							s_nxt.cnt = s_r.cnt + 8'h01;
							ovf_evt = 1'b1;
						end else begin
							s_nxt.cnt = s_r.cnt - 8'h01;
						end
					end else if (s_r.cnt == `TMR2_MAX) begin
						s_nxt.dir_down = 1'b1;
						s_nxt.cnt = s_r.cnt - 8'h01;
					end else begin
						s_nxt.cnt = s_r.cnt + 8'h01;
					end
				end
				default: begin
					s_nxt.cnt = s_r.cnt;
				end
			endcase

			// Carrier waveform from the compare match
			case (wave)
				tmr2_pkg::TMR2_NORMAL,
				tmr2_pkg::TMR2_CTC: begin
					if (cmp_evt) begin
						case (carrier_mode)
							2'h1: s_nxt.oc2 = !s_r.oc2;
							2'h2: s_nxt.oc2 = 1'b0;
							2'h3: s_nxt.oc2 = 1'b1;
							default: s_nxt.oc2 = s_r.oc2;
						endcase
					end
				end
				tmr2_pkg::TMR2_FAST_PWM: begin
					if (carrier_mode[1]) begin
						// Match at top is ignored, bottom action only
						if (s_r.cnt == `TMR2_MAX) begin
							s_nxt.oc2 = !carrier_mode[0];
						end else if (cmp_evt) begin
							s_nxt.oc2 = carrier_mode[0];
						end
					end
				end
				tmr2_pkg::TMR2_PHASE_PWM: begin
					// At top the counter is still rising, so up action
					if (carrier_mode[1] && cmp_evt) begin
						if (s_r.dir_down) begin
							s_nxt.oc2 = !carrier_mode[0];
						end else begin
							s_nxt.oc2 = carrier_mode[0];
						end
					end
				end
				default: begin
					s_nxt.oc2 = s_r.oc2;
				end
			endcase
		end

		// Software write beats the tick in the same cycle
		if (wr_cnt) begin
			s_nxt.cnt = io_req.wdata;
			s_nxt.block = 1'b1;
		end
		if (wr_ocr) begin
			s_nxt.ocr = io_req.wdata;
		end
		if (wr_msk) begin
			s_nxt.mask_cmp = io_req.wdata[`TMR2_CMP_BIT];
			s_nxt.mask_ovf = io_req.wdata[`TMR2_OVF_BIT];
		end

		// Clears first so a same-cycle event wins
		if ((wr_flg && io_req.wdata[`TMR2_CMP_BIT]) || compare_vector_ack) begin
			s_nxt.flag_cmp = 1'b0;
		end
		if (cmp_evt) begin
			s_nxt.flag_cmp = 1'b1;
		end
		if ((wr_flg && io_req.wdata[`TMR2_OVF_BIT]) || overflow_vector_ack) begin
			s_nxt.flag_ovf = 1'b0;
		end
		if (ovf_evt) begin
			s_nxt.flag_ovf = 1'b1;
		end

		s_nxt.cmp_irq = s_r.flag_cmp && s_r.mask_cmp &&
			global_irq_enable;
		s_nxt.ovf_irq = s_r.flag_ovf && s_r.mask_ovf &&
			global_irq_enable;

		if (io_req.re) begin
			if (hit(io_req.addr, `TMR2_ADDR_COUNT)) begin
				s_nxt.rdata = s_r.cnt;
			end else if (hit(io_req.addr, `TMR2_ADDR_COMPARE)) begin
				s_nxt.rdata = s_r.ocr;
			end else if (hit(io_req.addr, `TMR2_ADDR_FLAGS)) begin
				s_nxt.rdata = {s_r.flag_cmp, s_r.flag_ovf, 6'h00};
			end else if (hit(io_req.addr, `TMR2_ADDR_MASK)) begin
				s_nxt.rdata = {s_r.mask_cmp, s_r.mask_ovf, 6'h00};
			end else begin
				s_nxt.rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.cnt <= `TMR2_RST_COUNT;
			s_r.ocr <= `TMR2_RST_COMPARE;
		end else begin
			s_r <= s_nxt;
		end
	end

	tmr2_modulator u_mod (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.carrier_compare_output(s_r.oc2),
		.modulating_compare_output(modulating_compare_output),
		.carrier_mode(carrier_mode),
		.modulating_mode(modulating_mode),
		.shared_pin_output_latch(shared_pin_output_latch),
		.shared_pin_direction(shared_pin_direction),
		.legacy_mode(s_r.fuse_sync),
		.pin_out(shared_pin_out),
		.pin_oe_n(shared_pin_oe_n)
	);

	assign io_rdata = s_r.rdata;
	assign carrier_compare_output = s_r.oc2;
	assign compare_irq_req = s_r.cmp_irq;
	assign overflow_irq_req = s_r.ovf_irq;

	property p_cnt_write;
		@(posedge ref_clk) disable iff (!rst_n)
		wr_cnt |=> s_r.cnt == $past(io_req.wdata) && s_r.block;
	endproperty
	a_cnt_write: assert property (p_cnt_write)
		else $error("counter write not taken");

	property p_cnt_read;
		@(posedge ref_clk) disable iff (!rst_n)
		io_req.re && hit(io_req.addr, `TMR2_ADDR_COUNT)
		|=> io_rdata == $past(s_r.cnt);
	endproperty
	a_cnt_read: assert property (p_cnt_read)
		else $error("counter read wrong");

	property p_block;
		@(posedge ref_clk) disable iff (!rst_n)
		s_r.block && timer_tick && !s_r.flag_cmp |=> !s_r.flag_cmp;
	endproperty
	a_block: assert property (p_block)
		else $error("compare not blocked after counter write");

	property p_match;
		@(posedge ref_clk) disable iff (!rst_n)
		timer_tick && !s_r.block && s_r.cnt == s_r.ocr
		|=> s_r.flag_cmp ##1 (compare_irq_req ==
			($past(s_r.mask_cmp) && $past(global_irq_enable)));
	endproperty
	a_match: assert property (p_match)
		else $error("match did not set compare flag");

	property p_ovf_max;
		@(posedge ref_clk) disable iff (!rst_n)
		timer_tick && wave != tmr2_pkg::TMR2_PHASE_PWM &&
		s_r.cnt == `TMR2_MAX |=> s_r.flag_ovf;
	endproperty
	a_ovf_max: assert property (p_ovf_max)
		else $error("overflow flag not set at max");

	property p_ovf_pc;
		@(posedge ref_clk) disable iff (!rst_n)
		timer_tick && wave == tmr2_pkg::TMR2_PHASE_PWM &&
		s_r.dir_down && s_r.cnt == `TMR2_BOTTOM
		|=> s_r.flag_ovf && !s_r.dir_down;
	endproperty
	a_ovf_pc: assert property (p_ovf_pc)
		else $error("overflow flag not set at bottom turn");

	property p_cmp_clear;
		@(posedge ref_clk) disable iff (!rst_n)
		(compare_vector_ack || (wr_flg && io_req.wdata[`TMR2_CMP_BIT]))
		&& !cmp_evt |=> !s_r.flag_cmp;
	endproperty
	a_cmp_clear: assert property (p_cmp_clear)
		else $error("compare flag not cleared");

	property p_ovf_clear;
		@(posedge ref_clk) disable iff (!rst_n)
		(overflow_vector_ack || (wr_flg && io_req.wdata[`TMR2_OVF_BIT]))
		&& !ovf_evt |=> !s_r.flag_ovf;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear)
		else $error("overflow flag not cleared");

	property p_cmp_irq;
		@(posedge ref_clk) disable iff (!rst_n)
		s_r.flag_cmp && s_r.mask_cmp && global_irq_enable
		|=> compare_irq_req;
	endproperty
	a_cmp_irq: assert property (p_cmp_irq)
		else $error("compare interrupt not raised");

	property p_ovf_irq;
		@(posedge ref_clk) disable iff (!rst_n)
		!(s_r.flag_ovf && s_r.mask_ovf && global_irq_enable)
		|=> !overflow_irq_req;
	endproperty
	a_ovf_irq: assert property (p_ovf_irq)
		else $error("overflow interrupt without cause");

	c_match: cover property (@(posedge ref_clk) disable iff (!rst_n)
		cmp_evt ##1 s_r.flag_cmp);
	c_ovf_pc: cover property (@(posedge ref_clk) disable iff (!rst_n)
		ovf_evt && wave == tmr2_pkg::TMR2_PHASE_PWM);
	c_block: cover property (@(posedge ref_clk) disable iff (!rst_n)
		s_r.block && timer_tick && s_r.cnt == s_r.ocr);
endmodule // tmr2_regs
`default_nettype wire
